// ===== inc/orc_pkg.sv
// package for the oscillator control and reference clock block
// assumes a single 100 MHz system clock and an APB master with 32-bit data
package orc_pkg;
    // ----------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] OFS_OSC_CTRL = 8'h00;
    localparam logic [7:0] OFS_OSC_STAT = 8'h04;
    localparam logic [7:0] OFS_OSC_TUNE = 8'h08;
    localparam logic [7:0] OFS_REF_CTRL = 8'h0c;
    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [7:0] RST_OSC_CTRL = 8'h38;
    localparam logic [7:0] RST_OSC_TUNE = 8'h00;
    localparam logic [7:0] RST_REF_CTRL = 8'h30;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int CTL_SOFT_PLL = 7;
    localparam int CTL_FREQ_LSB = 3;
    localparam int CTL_SRC_LSB = 0;
    localparam int REF_UNIT_ON = 7;
    localparam int REF_PIN_DRIVE = 6;
    localparam int REF_SLEW = 5;
    localparam int REF_DUTY_LSB = 3;
    localparam int REF_DIV_LSB = 0;
    localparam logic [7:0] CTL_WR_MASK = 8'hfb;
    localparam logic [7:0] TUNE_WR_MASK = 8'h3f;
    // ----------------------------------------
    // configuration oscillator mode codes
    // ----------------------------------------
    localparam logic [2:0] MODE_LOW_POWER_CRYSTAL = 3'h0;
    localparam logic [2:0] MODE_CRYSTAL = 3'h1;
    localparam logic [2:0] MODE_HIGH_SPEED_CRYSTAL = 3'h2;
    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [1:0] {SRC_CONFIG, SRC_TIMER1, SRC_INTERNAL} orc_src_e;
    typedef enum logic [1:0] {OSC_LOW, OSC_MID, OSC_HIGH} orc_osc_e;
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } orc_apb_req_s;
    typedef struct packed {
        logic timer1Ready;
        logic pllReady;
        logic runFromConfig;
        logic highReady;
        logic highLocked;
        logic midReady;
        logic lowReady;
        logic highStable;
    } orc_osc_flags_s;
endpackage

// ===== hdl/orc_osc_ref.sv
// oscillator control/status registers and reference clock output generator
// assumes APB master on core_clk, configuration word bits held steady as inputs
// Functional notes
// - configuration PLL force keeps 4x PLL on; otherwise control bit 7 decides
// - freq select 000x low 31k, 0010/0011 31.25k mid/high, 01xx mid 62.5-500k
// - freq select 1000-1111 give high oscillator 125k up to 16 MHz, 32 with PLL
// - source select 1x internal block, 01 Timer1, 00 configuration mode
// - status bit 7 is Timer1 ready, or 1 while Timer1 oscillator disabled
// - status bit 5 shows running from the configuration-selected clock
// - status bits 4, 2, 1 show high, mid, low oscillators ready
// - status bit 3 shows high oscillator within 2 percent
// - status bit 0 shows high oscillator within 0.5 percent
// - six-bit signed trim, zero is factory, 011111 max, 100000 min
// - reference unit runs only when enabled; pin needs its own enable
// - divided clock always feeds the modulator regardless of the pin
// - undivided mode follows source duty, 0 percent duty forces low
// - divide by two uses both source edges for 75 percent; at 25 percent it stays low
// - slew limiting follows the slew control bit
// - every reset disables the unit and restores register defaults
// - crystal modes keep the shared pin as oscillator input
// - configuration clock-out drives system clock divided by four, top priority
// - in sleep the unit stops and outputs hold their level
// - three-bit divider: 000 undivided, each step doubles up to 128
// - duty field: 11 75, 10 50, 01 25, 00 0 percent
// - reference control bit 7 unit enable, bit 6 pin enable, both reset 0
`timescale 1ns/1ps
module orc_osc_ref (
    input wire logic core_clk,                          // system clock, 100 MHz
    input wire logic rst_n,                             // synchronous reset, low
    input wire orc_pkg::orc_apb_req_s apbReq,           // apb request group
    output logic [31:0] prdata,                         // apb read data
    output logic pready,                                // apb ready
    output logic pslverr,                               // apb error, unmapped
    input wire logic cfgPllForce,                       // config word PLL force
    input wire logic cfgFoscQuarterOut,                 // config word clock-out
    input wire logic [2:0] cfgOscMode,                  // config word osc mode
    input wire logic timer1OscEnable,                   // Timer1 osc enable
    input wire orc_pkg::orc_osc_flags_s oscFlags,       // analog ready flags
    input wire logic sleepActive,                       // device asleep
    output logic pllOn,                                 // 4x PLL enable
    output orc_pkg::orc_src_e sysclkSourceSelect,       // chosen clock source
    output orc_pkg::orc_osc_e intOscSelect,             // internal osc used
    output logic [24:0] intFreqHz,                      // internal freq in Hz
    output logic signed [5:0] freqTrim,                 // oscillator trim
    output logic refclkToModulator,                     // clock to modulator
    output logic refclkOutputPin,                       // shared pin level
    output logic refclkPinOe_n,                         // pin enable, low drives
    output logic refclkSlewLimit                        // slew limit on pin
);
    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [7:0] oscCtrlFf;
    logic [7:0] oscTuneFf;
    logic [7:0] refCtrlFf;
    logic [7:0] nxt_refCtrl;
    logic [7:0] oscStatFf;
    logic [31:0] rdataFf;
    logic [6:0] divCntFf;
    logic [6:0] nxt_divCnt;
    logic refLvlFf;
    logic heldLvlFf;
    logic [1:0] quarterFf;
    logic unitOn;
    logic [2:0] divSel;
    logic [1:0] dutySel;
    logic [7:0] divN;
    logic [6:0] lastIdx;
    logic [7:0] highCnt;
    logic [7:0] nxtDivN;
    logic [7:0] nxtHighCnt;
    logic refLive;
    logic crystalMode;
    logic addrHit;
    logic wrEn;
    logic [7:0] rdSel;

    assign addrHit = apbReq.paddr == orc_pkg::OFS_OSC_CTRL
        || apbReq.paddr == orc_pkg::OFS_OSC_STAT
        || apbReq.paddr == orc_pkg::OFS_OSC_TUNE
        || apbReq.paddr == orc_pkg::OFS_REF_CTRL;
    assign wrEn = apbReq.psel && apbReq.penable && apbReq.pwrite && addrHit;
    // zero wait states: data is captured in setup, answered in access
    assign pready = apbReq.psel && apbReq.penable;
    assign pslverr = apbReq.psel && apbReq.penable && !addrHit;
    assign prdata = rdataFf;

    // ----------------------------------------
    // software registers
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            oscCtrlFf <= orc_pkg::RST_OSC_CTRL;
        end else if (wrEn && apbReq.paddr == orc_pkg::OFS_OSC_CTRL) begin
            oscCtrlFf <= apbReq.pwdata[7:0] & orc_pkg::CTL_WR_MASK;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            oscTuneFf <= orc_pkg::RST_OSC_TUNE;
        end else if (wrEn && apbReq.paddr == orc_pkg::OFS_OSC_TUNE) begin
            oscTuneFf <= apbReq.pwdata[7:0] & orc_pkg::TUNE_WR_MASK;
        end
    end

    // next value shared with the divider, so the write that enables
    // the unit already shapes the first output period
    always_comb begin
        nxt_refCtrl = refCtrlFf;
        if (wrEn && apbReq.paddr == orc_pkg::OFS_REF_CTRL) begin
            nxt_refCtrl = apbReq.pwdata[7:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            refCtrlFf <= orc_pkg::RST_REF_CTRL;
        end else begin
            refCtrlFf <= nxt_refCtrl;
        end
    end

    // status is sampled once a cycle so reads see a settled value
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            oscStatFf <= 8'h00;
        end else begin
            oscStatFf <= {!timer1OscEnable || oscFlags.timer1Ready,
                          oscFlags.pllReady,
                          oscFlags.runFromConfig,
                          oscFlags.highReady,
                          oscFlags.highLocked,
                          oscFlags.midReady,
                          oscFlags.lowReady,
                          oscFlags.highStable};
        end
    end

    always_comb begin
        case (apbReq.paddr)
            orc_pkg::OFS_OSC_CTRL: rdSel = oscCtrlFf;
            orc_pkg::OFS_OSC_STAT: rdSel = oscStatFf;
            orc_pkg::OFS_OSC_TUNE: rdSel = oscTuneFf;
            orc_pkg::OFS_REF_CTRL: rdSel = refCtrlFf;
            default: rdSel = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rdataFf <= 32'h00000000;
        end else if (apbReq.psel && !apbReq.penable && !apbReq.pwrite) begin
            rdataFf <= {24'h000000, rdSel};
        end
    end

    // ----------------------------------------
    // oscillator selection outputs
    // ----------------------------------------
    assign pllOn = cfgPllForce || oscCtrlFf[orc_pkg::CTL_SOFT_PLL];
    assign freqTrim = oscTuneFf[5:0];

    always_comb begin
        case (oscCtrlFf[orc_pkg::CTL_SRC_LSB +: 2])
            2'h2, 2'h3: sysclkSourceSelect = orc_pkg::SRC_INTERNAL;
            2'h1: sysclkSourceSelect = orc_pkg::SRC_TIMER1;
            default: sysclkSourceSelect = orc_pkg::SRC_CONFIG;
        endcase
    end

    always_comb begin
        intOscSelect = orc_pkg::OSC_HIGH;
        case (oscCtrlFf[orc_pkg::CTL_FREQ_LSB +: 4])
            4'h0, 4'h1: begin
                intOscSelect = orc_pkg::OSC_LOW;
                intFreqHz = 25'd31000;
            end
            4'h2: begin
                intOscSelect = orc_pkg::OSC_MID;
                intFreqHz = 25'd31250;
            end
            4'h3: intFreqHz = 25'd31250;
            4'h4: begin
                intOscSelect = orc_pkg::OSC_MID;
                intFreqHz = 25'd62500;
            end
            4'h5: begin
                intOscSelect = orc_pkg::OSC_MID;
                intFreqHz = 25'd125000;
            end
            4'h6: begin
                intOscSelect = orc_pkg::OSC_MID;
                intFreqHz = 25'd250000;
            end
            4'h7: begin
                intOscSelect = orc_pkg::OSC_MID;
                intFreqHz = 25'd500000;
            end
            4'h8: intFreqHz = 25'd125000;
            4'h9: intFreqHz = 25'd250000;
            4'ha: intFreqHz = 25'd500000;
            4'hb: intFreqHz = 25'd1000000;
            4'hc: intFreqHz = 25'd2000000;
            4'hd: intFreqHz = 25'd4000000;
            4'he: intFreqHz = pllOn ? 25'd32000000 : 25'd8000000;
            default: intFreqHz = 25'd16000000;
        endcase
    end

    // ----------------------------------------
    // reference clock divider
    // ----------------------------------------
    assign unitOn = refCtrlFf[orc_pkg::REF_UNIT_ON];
    assign divSel = refCtrlFf[orc_pkg::REF_DIV_LSB +: 3];
    assign dutySel = refCtrlFf[orc_pkg::REF_DUTY_LSB +: 2];
    assign divN = 8'h01 << divSel;
    assign lastIdx = 7'(divN - 8'h01);
    assign highCnt = 8'((10'(dutySel) * 10'(divN)) >> 2);
    assign nxtDivN = 8'h01 << nxt_refCtrl[orc_pkg::REF_DIV_LSB +: 3];
    assign nxtHighCnt = 8'((10'(nxt_refCtrl[orc_pkg::REF_DUTY_LSB +: 2])
        * 10'(nxtDivN)) >> 2);

    // counter held at zero while off so enabling starts a whole period
    always_comb begin
        if (!unitOn) begin
            nxt_divCnt = 7'h00;
        end else if (sleepActive) begin
            nxt_divCnt = divCntFf;
        end else if (divCntFf >= lastIdx) begin
            nxt_divCnt = 7'h00;
        end else begin
            nxt_divCnt = 7'(divCntFf + 7'h01);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            divCntFf <= 7'h00;
        end else begin
            divCntFf <= nxt_divCnt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            refLvlFf <= 1'b0;
        end else if (!sleepActive) begin
            refLvlFf <= nxt_refCtrl[orc_pkg::REF_UNIT_ON]
                && ({1'b0, nxt_divCnt} < nxtHighCnt);
        end
    end

    // undivided, and divide by two at 75 percent, the output is shaped by the clock level itself,
    // so duty accuracy rides on the source duty cycle
    always_comb begin
        if (!unitOn || dutySel == 2'h0) begin
            refLive = 1'b0;
        end else if (divSel == 3'h0) begin
            refLive = core_clk;
        end else if (divSel == 3'h1 && dutySel == 2'h1) begin
            refLive = refLvlFf && core_clk;
        end else if (divSel == 3'h1 && dutySel == 2'h3) begin
            refLive = refLvlFf || core_clk;
        end else begin
            refLive = refLvlFf;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            heldLvlFf <= 1'b0;
        end else if (!sleepActive) begin
            heldLvlFf <= refLvlFf;
        end
    end

    assign refclkToModulator = sleepActive ? heldLvlFf : refLive;

    // ----------------------------------------
    // shared pin
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            quarterFf <= 2'h0;
        end else if (!sleepActive) begin
            quarterFf <= 2'(quarterFf + 2'h1);
        end
    end

    assign crystalMode = cfgOscMode == orc_pkg::MODE_LOW_POWER_CRYSTAL
        || cfgOscMode == orc_pkg::MODE_CRYSTAL
        || cfgOscMode == orc_pkg::MODE_HIGH_SPEED_CRYSTAL;

    always_comb begin
        if (cfgFoscQuarterOut) begin
            refclkOutputPin = quarterFf[1];
            refclkPinOe_n = 1'b0;
        end else if (crystalMode) begin
            refclkOutputPin = 1'b0;
            refclkPinOe_n = 1'b1;
        end else if (unitOn && refCtrlFf[orc_pkg::REF_PIN_DRIVE]) begin
            refclkOutputPin = refclkToModulator;
            refclkPinOe_n = 1'b0;
        end else begin
            refclkOutputPin = 1'b0;
            refclkPinOe_n = 1'b1;
        end
    end

    assign refclkSlewLimit = refCtrlFf[orc_pkg::REF_SLEW];

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_pll_force_on: assert property (@(posedge core_clk) disable iff (!rst_n)
        cfgPllForce |-> pllOn) else $error("PLL off while forced");

    a_pll_soft_ctl: assert property (@(posedge core_clk) disable iff (!rst_n)
        !cfgPllForce |-> pllOn == oscCtrlFf[7]) else $error("PLL ignores soft bit");

    a_src_decode: assert property (@(posedge core_clk) disable iff (!rst_n)
        oscCtrlFf[1] |-> sysclkSourceSelect == orc_pkg::SRC_INTERNAL)
        else $error("source select wrong");

    a_t1_always_ready: assert property (@(posedge core_clk) disable iff (!rst_n)
        !timer1OscEnable ##1 1'b1 |-> oscStatFf[7]) else $error("Timer1 ready low");

    a_reset_defaults: assert property (@(posedge core_clk)
        !rst_n |=> refCtrlFf == 8'h30 && oscCtrlFf == 8'h38 && oscTuneFf == 8'h00)
        else $error("registers not at defaults");

    a_crystal_block: assert property (@(posedge core_clk) disable iff (!rst_n)
        crystalMode && !cfgFoscQuarterOut |-> refclkPinOe_n) else $error("pin driven");

    a_quarter_prio: assert property (@(posedge core_clk) disable iff (!rst_n)
        cfgFoscQuarterOut && !sleepActive ##1 cfgFoscQuarterOut && !sleepActive
        ##1 cfgFoscQuarterOut && !sleepActive
        |-> !refclkPinOe_n && refclkOutputPin != $past(refclkOutputPin, 2))
        else $error("clock-out not system clock over four");

    a_sleep_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        sleepActive && $past(sleepActive) |-> $stable(divCntFf) && $stable(heldLvlFf))
        else $error("divider moved in sleep");

    a_div_wrap: assert property (@(posedge core_clk) disable iff (!rst_n)
        unitOn && !sleepActive && divCntFf == lastIdx |=> divCntFf == 7'h00)
        else $error("divider did not wrap");

    a_enable_restart: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(unitOn) |-> divCntFf == 7'h00) else $error("counter not restarted");

    a_duty_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
        unitOn && dutySel == 2'h0 && !sleepActive ##1 dutySel == 2'h0 && !sleepActive
        |-> !refLvlFf && !refclkToModulator) else $error("zero duty not low");

    a_half_duty: assert property (@(posedge core_clk) disable iff (!rst_n)
        unitOn && divSel == 3'h2 && dutySel == 2'h2 && divCntFf == 7'h0 && !sleepActive
        ##1 !sleepActive && unitOn && divSel == 3'h2 && dutySel == 2'h2
        |-> refLvlFf) else $error("50 percent start not high");

    a_first_high: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(unitOn) && highCnt != 8'h00 && !$past(sleepActive) |-> refLvlFf)
        else $error("first period starts low");

    a_pin_route: assert property (@(posedge core_clk) disable iff (!rst_n)
        unitOn && refCtrlFf[orc_pkg::REF_PIN_DRIVE] && !crystalMode && !cfgFoscQuarterOut
        |-> !refclkPinOe_n && refclkOutputPin == refclkToModulator)
        else $error("reference not on pin");

endmodule // orc_osc_ref

// ===== dv/orc_ref_sink.sv
// partner model: an external device clocked from the shared reference pin
// assumes the pin level is resolved in the bench, sampled on core_clk edges
`timescale 1ns/1ps
module orc_ref_sink (
    input wire logic core_clk, // sampling clock
    input wire logic pinLevel, // resolved pin level
    output logic [15:0] riseCount, // rising edges seen
    output logic [15:0] fallCount, // falling edges seen
    output logic [15:0] lastPeriod, // cycles between rises
    output logic [15:0] lastHigh // cycles of last high time
);
    logic prevLevel = 1'h0;
    logic [15:0] sinceRise = 16'h0;
    logic [15:0] highRun = 16'h0;
    initial begin
        riseCount = 16'h0;
        fallCount = 16'h0;
        lastPeriod = 16'h0;
        lastHigh = 16'h0;
    end
    // whole cycles only: a pulse shorter than one clock is not seen
    always @(posedge core_clk) begin
        prevLevel <= pinLevel;
        sinceRise <= (pinLevel && !prevLevel) ? 16'h1 : sinceRise + 16'h1;
        highRun <= pinLevel ? highRun + 16'h1 : 16'h0;
        if (pinLevel && !prevLevel) begin
            riseCount <= riseCount + 16'h1;
            lastPeriod <= sinceRise;
        end
        if (!pinLevel && prevLevel) begin
            fallCount <= fallCount + 16'h1;
            lastHigh <= highRun;
        end
    end
endmodule // orc_ref_sink

// ===== dv/osc_ctrl_and_ref_clock_out_test.sv
// self-checking bench for the oscillator control and reference clock block
// assumes zero-wait apb slave and a board pull-down on the shared pin
`timescale 1ns/1ps
module osc_ctrl_and_ref_clock_out_test;
    logic core_clk = 1'h0;
    logic rst_n = 1'h0;
    orc_pkg::orc_apb_req_s apbReq = '0;
    logic [31:0] prdata;
    logic pready, pslverr, pllOn, refclkToModulator, refclkOutputPin, refclkPinOe_n;
    logic cfgPllForce = 1'h0, cfgFoscQuarterOut = 1'h0, timer1OscEnable = 1'h0;
    logic sleepActive = 1'h0, refclkSlewLimit, er, p, q;
    logic [2:0] cfgOscMode = 3'h4;
    orc_pkg::orc_osc_flags_s oscFlags = '0;
    orc_pkg::orc_src_e sysclkSourceSelect;
    orc_pkg::orc_osc_e intOscSelect;
    logic [24:0] intFreqHz;
    logic signed [5:0] freqTrim;
    logic [15:0] riseCount, fallCount, lastPeriod, lastHigh, r;
    logic [31:0] rd, d;
    int failures = 0, checkCount = 0, n;
    // released pin falls to the pull-down level
    wire pinLevel = refclkPinOe_n ? 1'h0 : refclkOutputPin;
    always #5 core_clk = ~core_clk;
    orc_osc_ref dut_u (.core_clk(core_clk), .rst_n(rst_n), .apbReq(apbReq), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cfgPllForce(cfgPllForce),
        .cfgFoscQuarterOut(cfgFoscQuarterOut), .cfgOscMode(cfgOscMode),
        .timer1OscEnable(timer1OscEnable), .oscFlags(oscFlags), .sleepActive(sleepActive),
        .pllOn(pllOn), .sysclkSourceSelect(sysclkSourceSelect), .intOscSelect(intOscSelect),
        .intFreqHz(intFreqHz), .freqTrim(freqTrim), .refclkToModulator(refclkToModulator),
        .refclkOutputPin(refclkOutputPin), .refclkPinOe_n(refclkPinOe_n),
        .refclkSlewLimit(refclkSlewLimit));
    orc_ref_sink sink_u (.core_clk(core_clk), .pinLevel(pinLevel), .riseCount(riseCount),
        .fallCount(fallCount), .lastPeriod(lastPeriod), .lastHigh(lastHigh));
    // ----------------------------------------
    // checking and bus tasks
    // ----------------------------------------
    task automatic final_report();
        $display("checks %0d failures %0d", checkCount, failures);
        if (failures == 0 && checkCount > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic timeout();
        failures++;
        final_report();
    endtask
    task automatic checkWord(input logic [31:0] got, input logic [31:0] exp);
        checkCount++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic checkBit(input logic got, input logic exp);
        checkCount++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int k;
        @(posedge core_clk);
        apbReq <= '{1'h1, 1'h0, w, a, wd};
        @(posedge core_clk);
        apbReq.penable <= 1'h1;
        for (k = 0; k < 50; k++) begin
            @(posedge core_clk);
            if (pready === 1'h1) break;
        end
        if (k == 50) timeout();
        rd = prdata;
        er = pslverr;
        apbReq <= '0;
    endtask
    task automatic settle();
        @(posedge core_clk);
        #1;
    endtask
    task automatic waitEdge(input logic fall);
        logic [15:0] s;
        int k;
        s = fall ? fallCount : riseCount;
        for (k = 0; k < 600; k++) begin
            settle();
            if ((fall ? fallCount : riseCount) !== s) break;
        end
        if (k == 600) timeout();
    endtask
    task automatic modCount(output int c);
        logic pv;
        c = 0;
        pv = refclkToModulator;
        repeat (16) begin
            settle();
            if (refclkToModulator !== pv) c++;
            pv = refclkToModulator;
        end
    endtask
    // ----------------------------------------
    // expectations
    // ----------------------------------------
    function automatic logic [24:0] expHz(logic [3:0] f, logic pl);
        if (f < 2) return 25'h7918;
        if (f < 4) return 25'h7a12;
        if (f < 8) return 25'hf424 << (f - 4);
        if (f == 14 && pl) return 25'h1e84800;
        return 25'h1e848 << (f - 8);
    endfunction
    function automatic orc_pkg::orc_osc_e expOsc(logic [3:0] f);
        if (f < 2) return orc_pkg::OSC_LOW;
        if (f == 3 || f > 7) return orc_pkg::OSC_HIGH;
        return orc_pkg::OSC_MID;
    endfunction
    function automatic orc_pkg::orc_src_e expSrc(logic [1:0] s);
        return s[1] ? orc_pkg::SRC_INTERNAL : (s[0] ? orc_pkg::SRC_TIMER1 : orc_pkg::SRC_CONFIG);
    endfunction
    task automatic refRun(input logic [2:0] dv, input logic [1:0] dc);
        logic s;
        s = 1'($urandom);
        apb(1'h1, orc_pkg::OFS_REF_CTRL, {24'h0, 2'h3, s, dc, dv});
        waitEdge(1'h1);
        waitEdge(1'h0);
        checkWord({16'h0, lastHigh}, 32'(int'(dc) * (1 << dv) / 4));
        waitEdge(1'h1);
        checkWord({16'h0, lastPeriod}, 32'(1 << dv));
        checkBit(refclkSlewLimit, s);
        apb(1'h1, orc_pkg::OFS_REF_CTRL, 32'h0);
        repeat (4) settle();
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'ha8287457));
        repeat (8) @(posedge core_clk);
        rst_n <= 1'h1;
        apb(1'h0, orc_pkg::OFS_OSC_CTRL, 32'h0);
        checkWord(rd, 32'h38);
        apb(1'h0, orc_pkg::OFS_OSC_TUNE, 32'h0);
        checkWord(rd, 32'h0);
        apb(1'h0, orc_pkg::OFS_REF_CTRL, 32'h0);
        checkWord(rd & 32'hc0, 32'h0);
        apb(1'h0, 8'h10, 32'h0);
        checkBit(er, 1'h1);
        apb(1'h1, orc_pkg::OFS_OSC_STAT, 32'hff);
        checkBit(er, 1'h0);
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            cfgPllForce <= i[1];
            apb(1'h1, orc_pkg::OFS_OSC_CTRL, {24'h0, i[0], 7'h38});
            settle();
            checkBit(pllOn, i[1] | i[0]);
        end
        @(posedge core_clk);
        cfgPllForce <= 1'h0;
        for (int i = 0; i < 32; i++) begin
            apb(1'h1, orc_pkg::OFS_OSC_CTRL, {24'h0, i[4], i[3:0], 1'h1, i[1:0]});
            apb(1'h0, orc_pkg::OFS_OSC_CTRL, 32'h0);
            checkWord(rd, {24'h0, i[4], i[3:0], 1'h0, i[1:0]});
            settle();
            checkWord(32'(intOscSelect), 32'(expOsc(i[3:0])));
            checkWord(32'(intFreqHz), 32'(expHz(i[3:0], i[4])));
            checkWord(32'(sysclkSourceSelect), 32'(expSrc(i[1:0])));
        end
        repeat (8) begin
            @(posedge core_clk);
            oscFlags <= 8'($urandom);
            timer1OscEnable <= 1'($urandom);
            repeat (2) @(posedge core_clk);
            apb(1'h0, orc_pkg::OFS_OSC_STAT, 32'h0);
            d = {24'h0, timer1OscEnable ? oscFlags[7] : 1'h1, oscFlags[6:0]};
            checkWord(rd, d);
        end
        for (int i = 0; i < 4; i++) begin
            d = (i == 0) ? 32'h1f : ((i == 1) ? 32'h20 : $urandom);
            apb(1'h1, orc_pkg::OFS_OSC_TUNE, d);
            apb(1'h0, orc_pkg::OFS_OSC_TUNE, 32'h0);
            checkWord(rd, d & 32'h3f);
            checkWord({26'h0, freqTrim}, d & 32'h3f);
        end
        for (int dv = 1; dv < 8; dv++)
            for (int dc = 1; dc < 4; dc++)
                if (dv > 1 || dc == 2) refRun(dv[2:0], dc[1:0]);
        apb(1'h1, orc_pkg::OFS_REF_CTRL, 32'hc3);
        r = riseCount;
        repeat (24) settle();
        checkWord({16'h0, riseCount}, {16'h0, r});
        apb(1'h1, orc_pkg::OFS_REF_CTRL, 32'hc0);
        modCount(n);
        checkWord(n, 32'h0);
        checkBit(refclkToModulator, 1'h0);
        apb(1'h1, orc_pkg::OFS_REF_CTRL, 32'h91);
        settle();
        checkBit(refclkPinOe_n, 1'h1);
        modCount(n);
        checkBit(n > 2, 1'h1);
        for (int m = 0; m < 3; m++) begin
            @(posedge core_clk);
            cfgOscMode <= m[2:0];
            apb(1'h1, orc_pkg::OFS_REF_CTRL, 32'hd1);
            settle();
            checkBit(refclkPinOe_n, 1'h1);
            modCount(n);
            checkBit(n > 2, 1'h1);
        end
        @(posedge core_clk);
        cfgOscMode <= 3'h4;
        settle();
        checkBit(refclkPinOe_n, 1'h0);
        @(posedge core_clk);
        cfgFoscQuarterOut <= 1'h1;
        apb(1'h1, orc_pkg::OFS_REF_CTRL, 32'hd5);
        repeat (3) waitEdge(1'h0);
        checkWord({16'h0, lastPeriod}, 32'h4);
        checkWord({16'h0, lastHigh}, 32'h2);
        @(posedge core_clk);
        cfgFoscQuarterOut <= 1'h0;
        apb(1'h1, orc_pkg::OFS_REF_CTRL, 32'hd3);
        repeat (5) settle();
        @(posedge core_clk);
        sleepActive <= 1'h1;
        repeat (2) settle();
        p = pinLevel;
        q = refclkToModulator;
        r = riseCount;
        repeat (30) settle();
        checkBit(pinLevel, p);
        checkBit(refclkToModulator, q);
        checkWord({16'h0, riseCount}, {16'h0, r});
        @(posedge core_clk);
        sleepActive <= 1'h0;
        rst_n <= 1'h0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'h1;
        settle();
        checkBit(refclkPinOe_n, 1'h1);
        apb(1'h0, orc_pkg::OFS_REF_CTRL, 32'h0);
        checkWord(rd, 32'(orc_pkg::RST_REF_CTRL));
        final_report();
    end
endmodule // osc_ctrl_and_ref_clock_out_test
